// *** src/rtc_tick_top.sv ***
// Periodic tick timer on the slow oscillator with an AXI4-Lite register slave.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rtc_tick_cfg.svh"
module rtc_tick_top #(
    parameter int CNT_W = `RTC_CNT_W
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rtc_tick_pkg::power_mode_t power_mode,
    input wire logic xtal_osc_pin,
    input wire logic cr_osc_pin,
    output logic xtal_osc_enable,
    output logic cr_osc_enable,
    output logic periodic_tick_irq,
    output logic wake_to_normal
);
    logic [7:0] tick_control_reg_q;
    logic [7:0] slow_osc_function_reg_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic irq_q;
    logic wake_q;
    logic xtal_en_q;
    logic cr_en_q;
    rtc_tick_pkg::power_mode_t mode_prev_q;

    logic aw_full_q;
    logic w_full_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic slow_rise;
    logic slow_pin_sel;
    logic do_write;
    logic ctrl_wr;
    logic func_wr;
    logic stop_exit;
    logic count_en;
    logic period_done;
    logic [2:0] period_sel;
    logic count_run_bit;
    logic [CNT_W-1:0] tap_mask;

    // Log2 of the number of slow clocks in one tick period for a select code.
    function automatic int period_exp(input logic [2:0] sel);
        int e;
        e = `RTC_EXP_SEL000;
        case (sel)
            3'h0: e = `RTC_EXP_SEL000;
            3'h1: e = `RTC_EXP_SEL001;
            3'h2: e = `RTC_EXP_SEL010;
            3'h3: e = `RTC_EXP_SEL011;
            3'h4, 3'h6: e = `RTC_EXP_SEL1X0;
            3'h5, 3'h7: e = `RTC_EXP_SEL1X1;
            default: e = `RTC_EXP_SEL000;
        endcase
        return e;
    endfunction

    // Mask of the counter bits that make up one period.
    function automatic logic [CNT_W-1:0] period_mask(input logic [2:0] sel);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1};
        return CNT_W'((one << period_exp(sel)) - one);
    endfunction

    // Register field views.
    assign period_sel = tick_control_reg_q[`RTC_CTRL_SEL_MSB:`RTC_CTRL_SEL_LSB]; // [RULE2]
    assign count_run_bit = tick_control_reg_q[`RTC_CTRL_RUN_BIT];
    assign tap_mask = period_mask(period_sel);

    // The slow source is muxed before the synchroniser; a source switch may cost one edge.
    assign slow_pin_sel = slow_osc_function_reg_q[`RTC_FUNC_CR_SEL_BIT] ? cr_osc_pin
                                                                        : xtal_osc_pin; // [RULE10]

    slow_edge_detect slow_edge_detect_inst (
        .ref_clk(ref_clk),
        .srst(srst),
        .slow_pin(slow_pin_sel),
        .slow_rise(slow_rise)
    );

    // AXI4-Lite write path: address and data are taken in either order.
    assign do_write = aw_full_q & w_full_q & ~bvalid_q;
    assign ctrl_wr = do_write & w_lane0_q & (aw_addr_q == `RTC_CTRL_OFS);
    assign func_wr = do_write & w_lane0_q & (aw_addr_q == `RTC_FUNC_OFS);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid & awready_q) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (bvalid_q & s_axi_bready) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid & wready_q) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (bvalid_q & s_axi_bready) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RTC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            case (aw_addr_q)
                `RTC_CTRL_OFS, `RTC_FUNC_OFS, `RTC_COUNT_OFS: bresp_q <= `RTC_RESP_OKAY;
                default: bresp_q <= `RTC_RESP_SLVERR;
            endcase
        end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // AXI4-Lite read path: data follows one cycle after the address is taken.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RTC_RESP_OKAY;
        end else if (s_axi_arvalid & arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= `RTC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `RTC_CTRL_OFS: rdata_q <= {24'h00_0000, tick_control_reg_q};
                `RTC_FUNC_OFS: rdata_q <= {24'h00_0000, slow_osc_function_reg_q};
                `RTC_COUNT_OFS: rdata_q <= 32'(cnt_q);
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `RTC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q & s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // Control register; the unused upper bits always read zero.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tick_control_reg_q <= `RTC_CTRL_RESET; // [RULE13]
        end else if (ctrl_wr) begin
            tick_control_reg_q <= w_data_q & `RTC_CTRL_WMASK;
        end
    end

    // Function register; a STOP exit wins over a write in the same cycle.
    assign stop_exit = (mode_prev_q == rtc_tick_pkg::pm_stop) &&
                       (power_mode != rtc_tick_pkg::pm_stop);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slow_osc_function_reg_q <= `RTC_FUNC_RESET;
            mode_prev_q <= rtc_tick_pkg::pm_normal;
        end else begin
            mode_prev_q <= power_mode;
            if (stop_exit) begin
                slow_osc_function_reg_q <= `RTC_FUNC_RESET; // [RULE6]
            end else if (func_wr) begin
                slow_osc_function_reg_q <= w_data_q & `RTC_FUNC_WMASK; // [RULE8]
            end
        end
    end

    // Oscillator enables; both are off in STOP.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            xtal_en_q <= 1'b0;
            cr_en_q <= 1'b0;
        end else begin
            xtal_en_q <= slow_osc_function_reg_q[`RTC_FUNC_OSC_ON_BIT] &
                         ~slow_osc_function_reg_q[`RTC_FUNC_CR_SEL_BIT] &
                         (power_mode != rtc_tick_pkg::pm_stop); // [RULE8]
            cr_en_q <= slow_osc_function_reg_q[`RTC_FUNC_OSC_ON_BIT] &
                       slow_osc_function_reg_q[`RTC_FUNC_CR_SEL_BIT] &
                       (power_mode != rtc_tick_pkg::pm_stop); // [RULE10]
        end
    end

    // Slow-clock counter; settling time of the oscillator is left to software.
    assign count_en = slow_rise & count_run_bit &
                      slow_osc_function_reg_q[`RTC_FUNC_OSC_ON_BIT] &
                      (power_mode != rtc_tick_pkg::pm_stop); // [RULE1] [RULE4]
    assign period_done = count_en & ((cnt_q & tap_mask) == tap_mask); // [RULE12]

    always_comb begin
        cnt_d = cnt_q;
        if (!count_run_bit) begin
            cnt_d = '0; // [RULE3]
        end else if (count_en) begin
            cnt_d = cnt_q + CNT_W'(1); // [RULE1]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Tick request and wake request are single-cycle pulses.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= period_done; // [RULE12]
            wake_q <= period_done && (power_mode == rtc_tick_pkg::pm_idle); // [RULE5]
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign xtal_osc_enable = xtal_en_q;
    assign cr_osc_enable = cr_en_q;
    assign periodic_tick_irq = irq_q;
    assign wake_to_normal = wake_q;

    // Checks on the timer behaviour.
    sequence s_ctrl_write_run;
        ctrl_wr && w_data_q[`RTC_CTRL_RUN_BIT];
    endsequence

    sequence s_run_then_edge;
        count_run_bit && count_en;
    endsequence

    a_run_clears: assert property (@(posedge ref_clk) disable iff (srst)
        !count_run_bit |=> cnt_q == '0) // [RULE3]
        else $error("Counter not cleared while stopped.");

    a_run_counts: assert property (@(posedge ref_clk) disable iff (srst)
        s_run_then_edge |=> cnt_q == $past(cnt_q) + CNT_W'(1)) // [RULE1]
        else $error("Counter did not advance on a slow edge.");

    a_stop_freeze: assert property (@(posedge ref_clk) disable iff (srst)
        (power_mode == rtc_tick_pkg::pm_stop) && count_run_bit && !ctrl_wr
        |=> $stable(cnt_q)) // [RULE4]
        else $error("Counter moved in STOP.");

    a_tick_period: assert property (@(posedge ref_clk) disable iff (srst)
        periodic_tick_irq |-> $past(cnt_q & tap_mask) == $past(tap_mask)) // [RULE2]
        else $error("Tick not at the end of the selected period.");

    a_tick_single: assert property (@(posedge ref_clk) disable iff (srst)
        periodic_tick_irq |=> !periodic_tick_irq) // [RULE12]
        else $error("Tick request longer than one cycle.");

    a_tick_cause: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(periodic_tick_irq) |-> $past(count_en && count_run_bit)) // [RULE12]
        else $error("Tick without a running slow edge.");

    a_wake_idle: assert property (@(posedge ref_clk) disable iff (srst)
        wake_to_normal |-> periodic_tick_irq &&
        $past(power_mode) == rtc_tick_pkg::pm_idle) // [RULE5]
        else $error("Wake request without tick in standby.");

    a_stop_reinit: assert property (@(posedge ref_clk) disable iff (srst)
        stop_exit |=> slow_osc_function_reg_q == `RTC_FUNC_RESET) // [RULE6]
        else $error("Function register kept after STOP exit.");

    a_osc_start: assert property (@(posedge ref_clk) disable iff (srst)
        func_wr && !stop_exit && w_data_q == 8'h01 &&
        power_mode != rtc_tick_pkg::pm_stop ##1
        power_mode != rtc_tick_pkg::pm_stop && !stop_exit
        |=> xtal_osc_enable && !cr_osc_enable) // [RULE8]
        else $error("Writing 01h did not start the crystal oscillator.");

    a_cr_select: assert property (@(posedge ref_clk) disable iff (srst)
        cr_osc_enable |-> $past(slow_osc_function_reg_q[`RTC_FUNC_CR_SEL_BIT])) // [RULE10]
        else $error("CR oscillator on without select bit.");

    a_reset_ctrl: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(srst) |-> tick_control_reg_q == `RTC_CTRL_RESET && cnt_q == '0) // [RULE13]
        else $error("Control not cleared by reset.");

    a_run_write: assert property (@(posedge ref_clk) disable iff (srst)
        s_ctrl_write_run |=> count_run_bit) // [RULE3]
        else $error("Run bit write lost.");

    a_bresp_time: assert property (@(posedge ref_clk) disable iff (srst)
        do_write |=> s_axi_bvalid [*1] ##0 1) // [RULE8]
        else $error("Write response missing.");
endmodule

// *** shared/rtc_tick_cfg.svh ***
// Offsets, field positions, reset values and period figures of the periodic tick timer.
// What this block does and what software must do
// RULE1: Count ticks of the 32.768 kHz slow oscillator.
// RULE2: Period select picks one of six tick periods.
// RULE3: Run bit zero stops and clears counter.
// RULE4: Counting continues in all modes except STOP.
// RULE5: Tick wakes any non-STOP standby back to NORMAL.
// RULE6: Leaving STOP without reset reinitialises function register.
// RULE7: Software rewrites function register after every STOP exit.
// RULE8: Function register controls oscillator; 01h starts it.
// RULE9: Software starts oscillator, waits, then writes 03h.
// RULE10: CR select bit switches source to CR oscillator.
// RULE11: Software allows oscillator settling before trusting periods.
// RULE12: One-cycle tick request per completed selected period.
// RULE13: Reset clears period select and run bit.
`ifndef RTC_TICK_CFG_SVH
`define RTC_TICK_CFG_SVH

`define RTC_ADDR_W 8
`define RTC_CTRL_OFS 8'h00
`define RTC_FUNC_OFS 8'h04
`define RTC_COUNT_OFS 8'h08

`define RTC_CTRL_RUN_BIT 0
`define RTC_CTRL_SEL_LSB 1
`define RTC_CTRL_SEL_MSB 3
`define RTC_CTRL_RESET 8'h00
`define RTC_CTRL_WMASK 8'h0f

`define RTC_FUNC_OSC_ON_BIT 0
`define RTC_FUNC_CR_SEL_BIT 1
`define RTC_FUNC_RESET 8'h00
`define RTC_FUNC_WMASK 8'h03

`define RTC_SLOW_OSC_HZ 32768
`define RTC_CNT_W 16
`define RTC_EXP_SEL000 14
`define RTC_EXP_SEL001 13
`define RTC_EXP_SEL010 12
`define RTC_EXP_SEL011 11
`define RTC_EXP_SEL1X0 16
`define RTC_EXP_SEL1X1 15

`define RTC_RESP_OKAY 2'b00
`define RTC_RESP_SLVERR 2'b10

`endif

// *** shared/rtc_tick_pkg.sv ***
// Types shared by the periodic tick timer modules.
package rtc_tick_pkg;
    typedef enum logic [1:0] {
        pm_normal = 2'b00,
        pm_idle = 2'b01,
        pm_stop = 2'b10
    } power_mode_t;

    typedef enum logic [0:0] {
        src_xtal = 1'b0,
        src_cr = 1'b1
    } slow_src_t;
endpackage

// *** src/slow_edge_detect.sv ***
// Synchroniser and rising-edge detector for the slow oscillator pin.
`timescale 1ns/1ps
module slow_edge_detect (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic slow_pin,
    output logic slow_rise
);
    logic sync1_q;
    logic sync2_q;
    logic last_q;

    // The first stage is read only by the second one.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            sync1_q <= slow_pin;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
        end
    end

    assign slow_rise = sync2_q & ~last_q;
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the periodic tick timer and its register slave.
`timescale 1ns/1ps
`include "rtc_tick_cfg.svh"
module tb;
    localparam logic [1:0] ok_r = `RTC_RESP_OKAY;
    localparam logic [1:0] err_r = `RTC_RESP_SLVERR;
    logic ref_clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic xpin, cpin, xen, cen, irq, wake;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    rtc_tick_pkg::power_mode_t mode;
    int miscompares, num_checks, cycles, edges_left, ph, irq_n, wake_n;
    int m_ctrl, m_func, m_cnt, n, e, i0, w0;
    bit use_cr;

    rtc_tick_top rtc_tick_top_inst (
        .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_mode(mode), .xtal_osc_pin(xpin), .cr_osc_pin(cpin),
        .xtal_osc_enable(xen), .cr_osc_enable(cen), .periodic_tick_irq(irq),
        .wake_to_normal(wake)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // The ceiling sits above the longest run, which needs about 74500 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            close_out();
        end
    end

    // Slow pin generator and model counter; a burst always ends with the pin low so that
    // switching the source never leaves a stray rising edge behind.
    always @(posedge ref_clk) begin
        if (irq === 1'b1) irq_n++;
        if (wake === 1'b1) begin
            wake_n++;
            chk({31'b0, irq}, 32'h1);
        end
        if (edges_left > 0 || ph != 3) begin
            ph = (ph == 5) ? 0 : ph + 1;
            if (ph == 0) begin
                edges_left--;
                if (m_ctrl % 2 == 1 && m_func % 2 == 1 && (m_func / 2) % 2 == use_cr
                    && mode != rtc_tick_pkg::pm_stop) m_cnt = (m_cnt + 1) % 65536;
            end
            xpin <= !use_cr && ph < 3;
            cpin <= use_cr && ph < 3;
        end
    end

    task automatic pulse(input int k);
        edges_left = k;
        while (edges_left > 0 || ph != 3) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit aw_p = 1, w_p = 1;
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (aw_p && awready === 1'b1) begin
                aw_p = 0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                chk({30'b0, bresp}, {30'b0, er});
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        bit a_p = 1;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (a_p && arready === 1'b1) begin
                a_p = 0;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                chk(rdata, ex);
                chk({30'b0, rresp}, {30'b0, er});
                break;
            end
        end
    endtask

    task automatic set_ctrl(input int v);
        wr(`RTC_CTRL_OFS, v, 4'hf, ok_r);
        m_ctrl = v;
        if (v % 2 == 0) m_cnt = 0;
    endtask

    task automatic set_func(input int v);
        wr(`RTC_FUNC_OFS, v, 4'hf, ok_r);
        m_func = v;
    endtask

    // The enables lag the function register by one cycle, hence the wait.
    task automatic chk_en();
        logic on;
        on = m_func % 2 == 1 && mode != rtc_tick_pkg::pm_stop;
        repeat (2) @(posedge ref_clk);
        chk({30'b0, xen, cen}, {30'b0, on && m_func / 2 == 0, on && m_func / 2 == 1});
    endtask

    initial begin
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, xpin, cpin, use_cr} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        mode = rtc_tick_pkg::pm_normal;
        ph = 3;
        rnd = $urandom(32'h4007);
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(`RTC_CTRL_OFS, 32'h0, ok_r);
        rd(`RTC_FUNC_OFS, 32'h0, ok_r);
        rd(`RTC_COUNT_OFS, 32'h0, ok_r);
        rnd = $urandom;
        wr(8'h0c, rnd, 4'hf, err_r);
        rd(8'h0c, 32'h0, err_r);
        wr(`RTC_CTRL_OFS, rnd, 4'hf, ok_r);
        m_ctrl = rnd & 32'h0f;
        rd(`RTC_CTRL_OFS, m_ctrl, ok_r);
        wr(`RTC_CTRL_OFS, ~rnd, 4'he, ok_r);
        wr(`RTC_COUNT_OFS, rnd, 4'hf, ok_r);
        rd(`RTC_CTRL_OFS, m_ctrl, ok_r);
        rd(`RTC_COUNT_OFS, 32'h0, ok_r);
        set_ctrl(0);
        $display("test registers done");
        set_func(1);
        chk_en();
        set_ctrl(1);
        n = 5 + $urandom % 40;
        pulse(n);
        rd(`RTC_COUNT_OFS, m_cnt, ok_r);
        set_ctrl(0);
        rd(`RTC_COUNT_OFS, 32'h0, ok_r);
        pulse(4);
        rd(`RTC_COUNT_OFS, 32'h0, ok_r);
        set_func(3);
        chk_en();
        set_ctrl(1);
        use_cr = 1;
        pulse(n);
        use_cr = 0;
        pulse(7);
        rd(`RTC_COUNT_OFS, m_cnt, ok_r);
        set_func(1);
        $display("test source done");
        mode <= rtc_tick_pkg::pm_stop;
        pulse(9);
        chk_en();
        rd(`RTC_COUNT_OFS, m_cnt, ok_r);
        mode <= rtc_tick_pkg::pm_normal;
        m_func = 0;
        rd(`RTC_FUNC_OFS, 32'h0, ok_r);
        chk_en();
        set_func(1);
        mode <= rtc_tick_pkg::pm_idle;
        pulse(9);
        rd(`RTC_COUNT_OFS, m_cnt, ok_r);
        mode <= rtc_tick_pkg::pm_normal;
        $display("test stop done");
        for (int k = 0; k < 2; k++) begin
            e = 11 + k;
            set_ctrl(0);
            set_ctrl((3 - k) * 2 + 1);
            i0 = irq_n;
            w0 = wake_n;
            pulse((1 << e) - 1);
            chk(irq_n - i0, 0);
            pulse(1);
            chk(irq_n - i0, 1);
            chk(wake_n - w0, 0);
            mode <= rtc_tick_pkg::pm_idle;
            pulse(1 << e);
            chk(irq_n - i0, 2);
            chk(wake_n - w0, 1);
            mode <= rtc_tick_pkg::pm_normal;
        end
        $display("test ticks done");
        close_out();
    end
endmodule
